/* inc/fpcl_regs.vh */
`ifndef FPCL_REGS_VH
`define FPCL_REGS_VH

// core clock rate
`define FPCL_CORE_HZ          200000000
// internal start-up oscillator rate
`define FPCL_OSC_HZ           10000000
// core cycles per oscillator tick
`define FPCL_OSC_DIV          (`FPCL_CORE_HZ / `FPCL_OSC_HZ)
// start-up clock ticks from load_complete high to user mode
`define FPCL_INIT_TICKS       136
// reset time-out before status release under auto-restart, in us
`define FPCL_AUTO_RST_US      40
// same time-out in core cycles
`define FPCL_AUTO_RST_CYC     (`FPCL_AUTO_RST_US * (`FPCL_CORE_HZ / 1000000))

// controller states
`define FPCL_ST_RESET         3'h0
`define FPCL_ST_RELEASE       3'h1
`define FPCL_ST_LOAD          3'h2
`define FPCL_ST_WAIT_DONE     3'h3
`define FPCL_ST_INIT          3'h4
`define FPCL_ST_USER          3'h5
`define FPCL_ST_ERROR         3'h6

// synchroniser bit positions
`define FPCL_SY_RESTART       0
`define FPCL_SY_LCLK          1
`define FPCL_SY_CEIN          2
`define FPCL_SY_DONE          3
`define FPCL_SY_STATUS        4
`define FPCL_SY_UCLK          5
`define FPCL_SY_DATA_LO       6
`define FPCL_SY_W             14
// synchroniser reset value: idle level of every pin, so no false edge follows reset
`define FPCL_SY_IDLE          14'h0015

`endif

/* src/fpcl_buf2.v */
`timescale 1ns/1ps
`include "fpcl_regs.vh"

module fpcl_buf2 #(
	parameter WIDTH = 8,
	parameter DEPTH = 2,
	parameter AW    = 1
) (
	// clock and reset
	input  wire             i_core_clk,
	input  wire             i_nrst,
	input  wire             i_ce,
	input  wire             i_flush,
	// fill side
	input  wire             i_valid,
	output wire             o_ready,
	input  wire [WIDTH-1:0] i_data,
	// drain side
	output wire             o_valid,
	input  wire             i_ready,
	output wire [WIDTH-1:0] o_data
);

	reg  [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg  [AW-1:0]    wr_q;
	reg  [AW-1:0]    rd_q;
	reg  [AW:0]      cnt_q;
	wire             push;
	wire             pop;
	integer          i;

	assign o_ready = (cnt_q != DEPTH[AW:0]);
	assign o_valid = (cnt_q != {(AW+1){1'b0}});
	assign o_data  = mem_q[rd_q];
	assign push    = i_valid & o_ready;
	assign pop     = o_valid & i_ready;

	function [AW-1:0] fpcl_next;
		input [AW-1:0] p;
		begin
			fpcl_next = (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1}) ? {AW{1'b0}}
				: p + {{(AW-1){1'b0}}, 1'b1};
		end
	endfunction

	always @(posedge i_core_clk) begin
		if (!i_nrst) begin
			wr_q  <= {AW{1'b0}};
			rd_q  <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_q[i] <= {WIDTH{1'b0}};
			end
		end else if (i_ce) begin
			if (i_flush) begin
				wr_q  <= {AW{1'b0}};
				rd_q  <= {AW{1'b0}};
				cnt_q <= {(AW+1){1'b0}};
			end else begin
				if (push) begin
					mem_q[wr_q] <= i_data;
					wr_q        <= fpcl_next(wr_q);
				end
				if (pop) begin
					rd_q <= fpcl_next(rd_q);
				end
				if (push && !pop) begin
					cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
				end else if (pop && !push) begin
					cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule

/* src/fpcl_loader.v */
`timescale 1ns/1ps
`include "fpcl_regs.vh"

// How it works
// - after own load completes, chain_enable_out_n goes low to start the next device.
// - start-up begins only when the shared load_complete line reads high.
// - any low on the shared status line halts loading and enters the error state.
// - auto-restart on: status released after reset time-out, then reload.
// - auto-restart off: status held low until a restart low pulse.
// - user mode follows 136 start-up clock ticks after load_complete rises.
// - restart low-to-high, then status released, before any byte is taken.
// - one byte per load clock, taken until load_complete is released.
// - each byte captured on a rising edge of load_clock.
// - load_clock may stop for any time; loading just resumes, no time-out.
// - after the last byte load_complete is released high.
// - start-up runs from a 10 MHz internal tick, or from user clock edges when i_user_clk_sel is set; tick switched off afterwards.
// - load_clock edges after loading have no effect.
// - a loading error drives status low; restart pulse restarts loading.
// - next device in the chain takes data within one clock of hand-over.
// - internal start-up reaches user mode 6 to 20 us after load_complete.

module fpcl_loader #(
	parameter CNT_W       = 24,
	parameter LOAD_BYTES  = 24'h000400,
	parameter AUTO_RST_CYC = `FPCL_AUTO_RST_CYC,
	parameter BUF_DEPTH   = 2,
	parameter BUF_AW      = 1
) (
	// clock, reset, enable
	input  wire       i_core_clk,
	input  wire       i_nrst,
	input  wire       i_ce,
	// option straps
	input  wire       i_auto_restart,
	input  wire       i_user_clk_sel,
	input  wire       i_init_done_en,
	// host pins
	input  wire       i_load_restart_n,
	input  wire       i_load_clock,
	input  wire [7:0] i_load_data,
	input  wire       i_chain_enable_in_n,
	input  wire       i_user_clk,
	output wire       o_chain_enable_out_n,
	// open-drain status line
	input  wire       i_load_error_status_n,
	output wire       o_load_error_status_n,
	output wire       o_load_error_status_n_oe,
	// open-drain load complete line
	input  wire       i_load_complete,
	output wire       o_load_complete,
	output wire       o_load_complete_oe,
	// start-up results
	output wire       o_init_done,
	output wire       o_user_mode,
	output wire       o_osc_running,
	// configuration byte stream
	output wire       o_cfg_valid,
	input  wire       i_cfg_ready,
	output wire [7:0] o_cfg_data,
	input  wire       i_cfg_error
);

	localparam [2:0] ST_RESET     = `FPCL_ST_RESET;
	localparam [2:0] ST_RELEASE   = `FPCL_ST_RELEASE;
	localparam [2:0] ST_LOAD      = `FPCL_ST_LOAD;
	localparam [2:0] ST_WAIT_DONE = `FPCL_ST_WAIT_DONE;
	localparam [2:0] ST_INIT      = `FPCL_ST_INIT;
	localparam [2:0] ST_USER      = `FPCL_ST_USER;
	localparam [2:0] ST_ERROR     = `FPCL_ST_ERROR;
	localparam [31:0] INIT_W      = `FPCL_INIT_TICKS;
	localparam [31:0] DIV_W       = `FPCL_OSC_DIV;
	localparam [31:0] ARST_W      = AUTO_RST_CYC;
	localparam [7:0] INIT_TICKS   = INIT_W[7:0];
	localparam [4:0] OSC_DIV      = DIV_W[4:0];
	localparam [15:0] AUTO_RST    = ARST_W[15:0];
	localparam       SW           = `FPCL_SY_W;

	// pin synchronisers
	reg  [SW-1:0] sy1_q;
	reg  [SW-1:0] sy2_q;
	reg           lclk3_q;
	reg           uclk3_q;
	reg           rst3_q;
	wire [SW-1:0] pins;
	wire          restart_n;
	wire          lclk_rise;
	wire          uclk_rise;
	wire          restart_rise;
	wire          cein_n;
	wire          done_line;
	wire          status_line;
	wire [7:0]    data_s;

	// controller state
	reg  [2:0]       st_q;
	reg  [2:0]       st_d;
	reg  [CNT_W-1:0] bytes_q;
	reg  [CNT_W-1:0] bytes_d;
	reg  [7:0]       ticks_q;
	reg  [7:0]       ticks_d;
	reg  [4:0]       div_q;
	reg  [4:0]       div_d;
	reg  [15:0]      tmo_q;
	reg  [15:0]      tmo_d;
	reg              user_q;
	reg              user_d;
	reg              ceo_n_q;
	reg              ceo_n_d;
	reg              stat_drv_q;
	reg              stat_drv_d;
	reg              done_drv_q;
	reg              done_drv_d;
	reg              osc_q;
	reg              osc_d;

	wire             take;
	wire             buf_ready;
	wire             overflow;
	wire             tick;
	wire             flush;

	assign pins = {i_load_data, i_user_clk, i_load_error_status_n, i_load_complete,
		i_chain_enable_in_n, i_load_clock, i_load_restart_n};

	always @(posedge i_core_clk) begin
		if (!i_nrst) begin
			sy1_q   <= `FPCL_SY_IDLE;
			sy2_q   <= `FPCL_SY_IDLE;
			lclk3_q <= 1'b0;
			uclk3_q <= 1'b0;
			rst3_q  <= 1'b1;
		end else if (i_ce) begin
			sy1_q   <= pins;
			sy2_q   <= sy1_q;
			lclk3_q <= sy2_q[`FPCL_SY_LCLK];
			uclk3_q <= sy2_q[`FPCL_SY_UCLK];
			rst3_q  <= sy2_q[`FPCL_SY_RESTART];
		end
	end

	assign restart_n    = sy2_q[`FPCL_SY_RESTART];
	assign restart_rise = restart_n & ~rst3_q;
	assign lclk_rise    = sy2_q[`FPCL_SY_LCLK] & ~lclk3_q;
	assign uclk_rise    = sy2_q[`FPCL_SY_UCLK] & ~uclk3_q;
	assign cein_n       = sy2_q[`FPCL_SY_CEIN];
	assign done_line    = sy2_q[`FPCL_SY_DONE];
	assign status_line  = sy2_q[`FPCL_SY_STATUS];
	assign data_s       = sy2_q[`FPCL_SY_DATA_LO +: 8];

	// byte taken only while loading and selected, no idle time-out on the clock
	assign take     = (st_q == ST_LOAD) & ~cein_n & lclk_rise;
	assign overflow = take & ~buf_ready;
	assign flush    = (st_q == ST_RESET) | (st_q == ST_ERROR);

	// start-up tick: internal oscillator divider or user clock edges
	assign tick = i_user_clk_sel ? uclk_rise : (osc_q & (div_q == OSC_DIV - 5'h01));

	always @* begin
		st_d       = st_q;
		bytes_d    = bytes_q;
		ticks_d    = ticks_q;
		div_d      = div_q;
		tmo_d      = tmo_q;
		user_d     = user_q;
		ceo_n_d    = ceo_n_q;
		stat_drv_d = stat_drv_q;
		done_drv_d = done_drv_q;
		osc_d      = osc_q;
		if (osc_q) begin
			div_d = (div_q == OSC_DIV - 5'h01) ? 5'h00 : div_q + 5'h01;
		end
		case (st_q)
			ST_RESET: begin
				stat_drv_d = 1'b1;
				done_drv_d = 1'b1;
				ceo_n_d    = 1'b1;
				user_d     = 1'b0;
				osc_d      = 1'b0;
				bytes_d    = {CNT_W{1'b0}};
				if (restart_rise) begin
					stat_drv_d = 1'b0;
					st_d       = ST_RELEASE;
				end
			end
			ST_RELEASE: begin
				if (status_line) begin
					st_d = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (!status_line || overflow || i_cfg_error) begin
					st_d       = ST_ERROR;
					stat_drv_d = 1'b1;
					tmo_d      = 16'h0000;
				end else if (take) begin
					bytes_d = bytes_q + {{(CNT_W-1){1'b0}}, 1'b1};
					if (bytes_q == LOAD_BYTES - {{(CNT_W-1){1'b0}}, 1'b1}) begin
						done_drv_d = 1'b0;
						ceo_n_d    = 1'b0;
						st_d       = ST_WAIT_DONE;
					end
				end
			end
			ST_WAIT_DONE: begin
				if (!status_line || i_cfg_error) begin
					st_d       = ST_ERROR;
					stat_drv_d = 1'b1;
					tmo_d      = 16'h0000;
				end else if (done_line) begin
					st_d    = ST_INIT;
					ticks_d = 8'h00;
					osc_d   = ~i_user_clk_sel;
					div_d   = 5'h00;
				end
			end
			ST_INIT: begin
				if (tick) begin
					ticks_d = ticks_q + 8'h01;
					if (ticks_q == INIT_TICKS - 8'h01) begin
						st_d   = ST_USER;
						user_d = 1'b1;
						osc_d  = 1'b0;
					end
				end
			end
			ST_USER: begin
				user_d = 1'b1;
			end
			ST_ERROR: begin
				stat_drv_d = 1'b1;
				done_drv_d = 1'b1;
				ceo_n_d    = 1'b1;
				bytes_d    = {CNT_W{1'b0}};
				if (i_auto_restart) begin
					if (tmo_q == AUTO_RST - 16'h0001) begin
						stat_drv_d = 1'b0;
						st_d       = ST_RELEASE;
					end else begin
						tmo_d = tmo_q + 16'h0001;
					end
				end
			end
			default: begin
				st_d = ST_RESET;
			end
		endcase
		// restart low overrides every state; without auto-restart it ends the error
		if (!restart_n) begin
			st_d       = ST_RESET;
			stat_drv_d = 1'b1;
			done_drv_d = 1'b1;
			ceo_n_d    = 1'b1;
			user_d     = 1'b0;
			osc_d      = 1'b0;
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_nrst) begin
			st_q       <= ST_RESET;
			bytes_q    <= {CNT_W{1'b0}};
			ticks_q    <= 8'h00;
			div_q      <= 5'h00;
			tmo_q      <= 16'h0000;
			user_q     <= 1'b0;
			ceo_n_q    <= 1'b1;
			stat_drv_q <= 1'b1;
			done_drv_q <= 1'b1;
			osc_q      <= 1'b0;
		end else if (i_ce) begin
			st_q       <= st_d;
			bytes_q    <= bytes_d;
			ticks_q    <= ticks_d;
			div_q      <= div_d;
			tmo_q      <= tmo_d;
			user_q     <= user_d;
			ceo_n_q    <= ceo_n_d;
			stat_drv_q <= stat_drv_d;
			done_drv_q <= done_drv_d;
			osc_q      <= osc_d;
		end
	end

	// byte stream towards the configuration store
	fpcl_buf2 #(
		.WIDTH (8),
		.DEPTH (BUF_DEPTH),
		.AW    (BUF_AW)
	) u_buf (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_ce       (i_ce),
		.i_flush    (flush),
		.i_valid    (take),
		.o_ready    (buf_ready),
		.i_data     (data_s),
		.o_valid    (o_cfg_valid),
		.i_ready    (i_cfg_ready),
		.o_data     (o_cfg_data)
	);

	assign o_load_error_status_n    = 1'b0;
	assign o_load_error_status_n_oe = stat_drv_q;
	assign o_load_complete          = 1'b0;
	assign o_load_complete_oe       = done_drv_q;
	assign o_chain_enable_out_n     = ceo_n_q;
	assign o_user_mode              = user_q;
	assign o_init_done              = user_q & i_init_done_en;
	assign o_osc_running            = osc_q;

endmodule

/* verif/fpcl_host.sv */
`timescale 1ns/1ps
module fpcl_host #(
	parameter int LOW_CYC = 20
) (
	// clock and shared status
	input  wire        i_core_clk,
	input  wire        i_status_n,
	// load pins
	output logic       o_restart_n,
	output logic       o_clk,
	output logic [7:0] o_data,
	output logic       o_oe_pull,
	output logic       o_user_clk
);
	int misses    = 0;
	int uclk_left = 0;
	int uclk_div  = 0;
	initial begin
		o_user_clk  = 1'b0;
		o_restart_n = 1'b1;
		o_clk       = 1'b0;
		o_data      = 8'h00;
		o_oe_pull   = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge i_core_clk);
	endtask
	// restart pulse, then wait for release; status is only read
	task automatic restart;
		int i;
		cyc(1);
		o_restart_n <= 1'b0;
		cyc(LOW_CYC);
		o_restart_n <= 1'b1;
		for (i = 0; i < 200 && i_status_n !== 1'b1; i++)
			cyc(1);
		if (i == 200)
			misses++;
		cyc(LOW_CYC);
	endtask
	// one byte per 80 ns clock; clock rests low, data inverts after hold
	task automatic send(input logic [7:0] b);
		cyc(1);
		o_data <= b;
		cyc(4);
		o_clk <= 1'b1;
		cyc(4);
		o_data <= ~b;
		cyc(4);
		o_clk <= 1'b0;
		cyc(3);
	endtask
	// memory output-enable low pulse
	task automatic pulse(input int n);
		cyc(1);
		o_oe_pull <= 1'b1;
		cyc(n);
		o_oe_pull <= 1'b0;
	endtask
	// n rising user clock edges, then the clock rests
	task automatic user_clocks(input int n);
		int i;
		cyc(1);
		uclk_left <= n;
		cyc(1);
		for (i = 0; i < 8 * n + 16 && uclk_left != 0; i++)
			cyc(1);
		if (i == 8 * n + 16)
			misses++;
	endtask
	// user start-up clock, 40 ns period; kept running while status is low
	always @(posedge i_core_clk)
		if (uclk_left > 0 || i_status_n !== 1'b1) begin
			uclk_div <= (uclk_div == 3) ? 0 : uclk_div + 1;
			if (uclk_div == 3) begin
				o_user_clk <= ~o_user_clk;
				if (!o_user_clk && uclk_left > 0)
					uclk_left <= uclk_left - 1;
			end
		end
endmodule

/* verif/fpcl_chk.sv */
`timescale 1ns/1ps
module fpcl_chk #(
	parameter AUTO_RST_CYC = 50
) (
	// clock, reset, options
	input wire       i_core_clk,
	input wire       i_nrst,
	input wire       i_auto_restart,
	input wire       i_user_clk_sel,
	input wire       i_init_done_en,
	// shared lines
	input wire       i_load_restart_n,
	input wire       i_load_complete,
	input wire       o_chain_enable_out_n,
	input wire       o_load_error_status_n,
	input wire       o_load_error_status_n_oe,
	input wire       o_load_complete,
	input wire       o_load_complete_oe,
	// start-up and stream
	input wire       o_init_done,
	input wire       o_user_mode,
	input wire       o_osc_running,
	input wire       i_cfg_ready,
	input wire       o_cfg_valid,
	input wire [7:0] o_cfg_data
);
	localparam int LO = AUTO_RST_CYC - 2;
	localparam int HI = AUTO_RST_CYC + 8;
	logic [11:0] init_q;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	// cycles since load_complete rose
	always @(posedge i_core_clk)
		init_q <= (i_load_complete && !o_user_mode) ? init_q + 12'h001 : 12'h000;
	a_od_level: assert property (!o_load_error_status_n && !o_load_complete)
		else $error("open-drain value not low");
	a_init_gate: assert property (o_init_done == (o_user_mode && i_init_done_en))
		else $error("init done gating wrong");
	a_osc_off: assert property (o_user_mode |-> !o_osc_running)
		else $error("oscillator on in user mode");
	a_restart_release: assert property ($rose(i_load_restart_n) && o_load_error_status_n_oe
		|-> ##[1:6] !o_load_error_status_n_oe)
		else $error("status not released after restart");
	a_restart_reset: assert property (!i_load_restart_n [*8]
		|-> o_load_error_status_n_oe && o_load_complete_oe && !o_user_mode)
		else $error("restart low did not reset");
	a_chain_next: assert property ($fell(o_load_complete_oe) |-> !o_chain_enable_out_n)
		else $error("chain enable not passed on");
	a_init_time: assert property ($rose(o_user_mode) && !i_user_clk_sel
		|-> init_q >= 12'ha96 && init_q <= 12'hac8)
		else $error("start-up length wrong");
	a_user_done: assert property (o_user_mode |-> i_load_complete)
		else $error("user mode without load complete");
	a_error_hold: assert property ($rose(o_load_error_status_n_oe) && i_load_restart_n
		&& !i_auto_restart |=> o_load_error_status_n_oe [*8])
		else $error("status released without restart");
	a_auto_release: assert property ($rose(o_load_error_status_n_oe) && i_load_restart_n
		&& i_auto_restart |-> ##[LO:HI] !o_load_error_status_n_oe)
		else $error("auto restart time-out wrong");
	a_buf_hold: assert property (o_cfg_valid && !i_cfg_ready && !o_load_error_status_n_oe
		|=> o_load_error_status_n_oe || (o_cfg_valid && $stable(o_cfg_data)))
		else $error("stalled word lost");
	c_user: cover property ($rose(o_user_mode));
	c_auto: cover property ($fell(o_load_error_status_n_oe) && i_auto_restart);
	c_stall: cover property (o_cfg_valid && !i_cfg_ready);
endmodule
bind fpcl_loader fpcl_chk #(.AUTO_RST_CYC(AUTO_RST_CYC)) u_chk (.*);

/* verif/fpcl_loader_test.sv */
`timescale 1ns/1ps
`include "fpcl_regs.vh"
module fpcl_loader_test;
	localparam int NB  = 4;
	localparam int ARC = 50;
	localparam int INI = `FPCL_INIT_TICKS * `FPCL_OSC_DIV;
	logic       clk      = 1'b0;
	logic       nrst     = 1'b0;
	logic       auto_rst = 1'b0;
	logic       ce_in_n  = 1'b0;
	logic       rdy      = 1'b0;
	logic       cfg_err  = 1'b0;
	logic       ce       = 1'b1;
	logic       usel     = 1'b0;
	logic       idone_en = 1'b1;
	logic       dn_hold  = 1'b0;
	wire        rs_n, lclk, pull, uclk, ce_out_n, st_oe, st_v, dn_oe, dn_v;
	wire        idone, umode, osc, vld;
	wire  [7:0] ldat, cdat;
	wire        st_w = (st_oe ? st_v : 1'b1) && !pull;
	wire        dn_w = (dn_oe ? dn_v : 1'b1) && !dn_hold;
	logic [7:0] got[$];
	int         error_cnt = 0;
	int         compares  = 0;
	always #2.5 clk = ~clk;
	fpcl_host #(.LOW_CYC(20)) i_host (.i_core_clk(clk), .i_status_n(st_w),
		.o_restart_n(rs_n), .o_clk(lclk), .o_data(ldat), .o_oe_pull(pull), .o_user_clk(uclk));
	fpcl_loader #(.LOAD_BYTES(24'h000004), .AUTO_RST_CYC(ARC)) i_dut (.i_core_clk(clk),
		.i_nrst(nrst), .i_ce(ce), .i_auto_restart(auto_rst), .i_user_clk_sel(usel),
		.i_init_done_en(idone_en), .i_load_restart_n(rs_n), .i_load_clock(lclk),
		.i_load_data(ldat), .i_chain_enable_in_n(ce_in_n), .i_user_clk(uclk),
		.o_chain_enable_out_n(ce_out_n), .i_load_error_status_n(st_w),
		.o_load_error_status_n(st_v), .o_load_error_status_n_oe(st_oe), .i_load_complete(dn_w),
		.o_load_complete(dn_v), .o_load_complete_oe(dn_oe), .o_init_done(idone),
		.o_user_mode(umode), .o_osc_running(osc), .o_cfg_valid(vld), .i_cfg_ready(rdy),
		.o_cfg_data(cdat), .i_cfg_error(cfg_err));
	always @(posedge clk)
		if (vld === 1'b1 && rdy)
			got.push_back(cdat);
	task automatic sett(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", error_cnt, compares);
		if (error_cnt == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic pick(input int k);
		case (k)
			0: pick = umode;
			1: pick = st_oe;
			default: pick = st_w;
		endcase
	endfunction
	task automatic till(input int k, input int lim, output int n);
		for (n = 0; n < lim && pick(k) !== 1'b1; n++)
			sett(1);
		if (n == lim) begin
			error_cnt++;
			$display("CHECK FAILED wait %0d expected 1 seen 0", k);
			close_out();
		end
	endtask
	task automatic t_normal;
		int k;
		int n;
		i_host.restart();
		sett(1);
		chk("status", 8'h01, {7'h00, st_w});
		for (k = 0; k < NB; k++) begin
			i_host.send(8'ha0 + 8'(k));
			if (k == 1) begin
				sett(300);
				chk("full", 8'h01, {7'h00, vld});
				@(posedge clk) rdy <= 1'b1;
			end
		end
		sett(4);
		chk("done oe", 8'h00, {7'h00, dn_oe});
		chk("chain out", 8'h00, {7'h00, ce_out_n});
		chk("osc", 8'h01, {7'h00, osc});
		chk("empty", 8'h00, {7'h00, vld});
		i_host.send(8'h5a);
		sett(4);
		chk("count", 8'(NB), 8'(got.size()));
		for (k = 0; k < NB; k++)
			chk("byte", 8'ha0 + 8'(k), got[k]);
		till(0, 4000, n);
		chk("init", 8'h01, {7'h00, n > INI - 80 && n < INI + 40});
		chk("osc off", 8'h00, {7'h00, osc});
		chk("init done", 8'h01, {7'h00, idone});
	endtask
	task automatic t_overflow;
		@(posedge clk) rdy <= 1'b0;
		i_host.restart();
		i_host.send(8'h31);
		i_host.send(8'h32);
		i_host.send(8'h33);
		sett(4);
		chk("overflow", 8'h01, {7'h00, st_oe});
		sett(100);
		chk("held", 8'h01, {7'h00, st_oe});
		chk("flushed", 8'h00, {7'h00, vld});
		@(posedge clk) rdy <= 1'b1;
	endtask
	task automatic t_auto;
		int n;
		@(posedge clk) auto_rst <= 1'b1;
		ce_in_n <= 1'b1;
		got.delete();
		i_host.restart();
		i_host.send(8'h41);
		sett(4);
		chk("ignored", 8'h00, 8'(got.size()));
		@(posedge clk) ce_in_n <= 1'b0;
		i_host.send(8'h42);
		sett(4);
		chk("taken", 8'h01, 8'(got.size()));
		@(posedge clk) ce <= 1'b0;
		i_host.send(8'h43);
		@(posedge clk) ce <= 1'b1;
		sett(4);
		chk("frozen", 8'h01, 8'(got.size()));
		@(posedge clk) cfg_err <= 1'b1;
		@(posedge clk) cfg_err <= 1'b0;
		till(1, 10, n);
		till(2, 200, n);
		chk("auto", 8'h01, {7'h00, n > ARC - 10 && n < ARC + 10});
	endtask
	task automatic t_mem;
		@(posedge clk) auto_rst <= 1'b0;
		i_host.restart();
		i_host.send(8'h51);
		i_host.pulse(20);
		sett(30);
		chk("chain err", 8'h01, {7'h00, st_oe});
	endtask
	task automatic t_user;
		int k;
		@(posedge clk) usel <= 1'b1;
		idone_en <= 1'b0;
		i_host.restart();
		for (k = 0; k < NB - 1; k++)
			i_host.send(8'h60 + 8'(k));
		sett(16 * `FPCL_INIT_TICKS);
		chk("short load", 8'h01, {7'h00, dn_oe});
		i_host.restart();
		for (k = 0; k < NB; k++)
			i_host.send(8'h70 + 8'(k));
		sett(4);
		chk("no osc", 8'h00, {7'h00, osc});
		i_host.user_clocks(60);
		i_host.restart();
		dn_hold <= 1'b1;
		for (k = 0; k < NB; k++)
			i_host.send(8'h80 + 8'(k));
		i_host.user_clocks(`FPCL_INIT_TICKS);
		chk("done held", 8'h00, {7'h00, umode});
		@(posedge clk) dn_hold <= 1'b0;
		sett(4);
		i_host.user_clocks(`FPCL_INIT_TICKS - 1);
		sett(4);
		chk("user early", 8'h00, {7'h00, umode});
		i_host.user_clocks(1);
		sett(4);
		chk("user mode", 8'h01, {7'h00, umode});
		chk("init done off", 8'h00, {7'h00, idone});
	endtask
	initial begin
		#450000;
		error_cnt++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		sett(4);
		t_normal();
		t_overflow();
		t_auto();
		t_mem();
		t_user();
		chk("host waits", 8'h00, 8'(i_host.misses));
		close_out();
	end
endmodule
